//--- rtl/aptsf_pkg.sv
package aptsf_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_START_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PAUSE    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLK_EN   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;

  // Counts of modules and start sources
  localparam int NUM_ADC = 2;
  localparam int NUM_PWM = 4;
  localparam int NUM_SRC = 4;

  // Start source numbering inside one ADC's enable nibble
  localparam int SRC_PIN   = 0;
  localparam int SRC_DONE  = 1;
  localparam int SRC_PWM   = 2;
  localparam int SRC_MATCH = 3;

  // Trigger timer match that starts the PWM chain
  localparam int PWM_KICK_MATCH = 3;

  // Field positions
  localparam int CLK_EN_ADC_LSB = 0;
  localparam int CLK_EN_PWM_LSB = 2;
  localparam int STAT_CNT0_LSB  = 8;
  localparam int STAT_CNT1_LSB  = 16;

  // Values after reset
  localparam logic [7:0] RST_START_EN = 8'h00;
  localparam logic [1:0] RST_EDGE_SEL = 2'h3;
  localparam logic       RST_PAUSE    = 1'b0;
  localparam logic [5:0] RST_CLK_EN   = 6'h3F;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

endpackage

//--- rtl/aptsf_edge_detect.sv
`timescale 1ns/1ps
// Optional two-stage synchroniser followed by an edge detector
module aptsf_edge_detect
  import aptsf_pkg::*;
#(
  parameter bit DO_SYNC = 1'b1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic sigIn,
  input  wire logic useRise,
  output logic      pulse,
  output logic      level
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic cur;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= sigIn;
      sync_ff <= meta_ff;
    end
  end

  assign cur = DO_SYNC ? sync_ff : sigIn;

  // Previous level, for the edge compare
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= cur;
    end
  end

  // One pulse per edge, whatever the level's length
  assign pulse = useRise ? (cur & ~prev_ff) : (~cur & prev_ff);
  assign level = cur;

endmodule // aptsf_edge_detect

//--- rtl/aptsf_fabric.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - Each ADC has four start inputs; any enabled one starts it while that ADC's clock is enabled.
// - Start 0 is the external pin, on a selectable rising or falling edge.
// - Start 1 is the other ADC's done pulse, captured on the bus clock.
// - ADC 0 done feeds ADC 1 start 1, and ADC 1 done feeds ADC 0.
// - Start 2 is the OR of the PWM period markers, edge-detected without resynchronisation.
// - Start 3 of both ADCs comes from trigger timer match outputs.
// - PWM 0 sync and transfer arm come from trigger timer fourth match.
// - Sync cascades PWM to PWM; each PWM applies its own delay.
// - Each carrier timer match drives the matching PWM carrier input while that PWM's clock is enabled.
// - Carrier timer pause comes from an external pin through a two-stage synchroniser.
// - Carrier timer stops advancing while its pause is asserted.
// - Trigger timer pause is the NOR of all PWM period markers, ANDed with the pause register bit.
// - With gating on, trigger timer advances only while a marker is high.
// - Both timers' capture inputs see the ADC start pulses, for debug.
// - Each ADC has separate bus-side and conversion clock areas.
// - Unused PWM or ADC clocks can be gated off without disturbing others.
module aptsf_fabric
  import aptsf_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [DATA_W-1:0]  wrData,
  input  wire logic               wrEn,
  input  wire logic               rdEn,
  output logic      [DATA_W-1:0]  rdData,
  input  wire logic [NUM_ADC-1:0] extStartPin,
  input  wire logic [NUM_ADC-1:0] adcDone,
  input  wire logic [NUM_PWM-1:0] pwmSyncOut,
  input  wire logic [NUM_PWM-1:0] trigTimerMatch,
  input  wire logic [NUM_PWM-1:0] carrierTimerMatch,
  input  wire logic               carrierPausePin,
  output logic      [NUM_ADC-1:0] adcStart,
  output logic      [NUM_ADC-1:0] trigTimerCapture,
  output logic      [NUM_ADC-1:0] carrierTimerCapture,
  output logic      [NUM_PWM-1:0] pwmSyncIn,
  output logic                    pwmTransArm0,
  output logic      [NUM_PWM-1:0] pwmCarrier,
  output logic                    trigTimerPause,
  output logic                    carrierTimerPause,
  output logic      [NUM_ADC-1:0] adcBusClkEn,
  output logic      [NUM_ADC-1:0] adcConvClkEn,
  output logic      [NUM_PWM-1:0] pwmClkEn
);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0]         startEn_ff;
  logic [NUM_ADC-1:0] edgeRise_ff;
  logic               pauseEn_ff;
  logic [5:0]         clkEn_ff;
  logic [7:0]         startCnt0_ff;
  logic [7:0]         startCnt1_ff;
  logic [DATA_W-1:0]  rdData_ff;

  // Software writes; strobes never wait
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startEn_ff  <= RST_START_EN;
      edgeRise_ff <= RST_EDGE_SEL;
      pauseEn_ff  <= RST_PAUSE;
      clkEn_ff    <= RST_CLK_EN;
    end else if (wrEn) begin
      unique case (addr)
        OFS_START_EN: startEn_ff  <= wrData[7:0];
        OFS_EDGE_SEL: edgeRise_ff <= wrData[NUM_ADC-1:0];
        OFS_PAUSE:    pauseEn_ff  <= wrData[0];
        OFS_CLK_EN:   clkEn_ff    <= wrData[5:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start source capture

  logic [NUM_ADC-1:0] pinPulse;
  logic [NUM_ADC-1:0] pinLevel;
  logic [NUM_ADC-1:0] donePulse;
  logic               markerPulse;
  logic               matchPulse;
  logic               carrierPauseLvl;
  logic [NUM_SRC-1:0] srcPulse [NUM_ADC];
  logic [NUM_SRC-1:0] srcEn    [NUM_ADC];
  logic [NUM_ADC-1:0] startNow;

  genvar a;
  generate
    for (a = 0; a < NUM_ADC; a++) begin : g_adc
      // Pin is asynchronous, so it is synchronised first
      aptsf_edge_detect #(.DO_SYNC(1'b1)) u_pin (
        .clk     (clk),
        .resetn  (resetn),
        .sigIn   (extStartPin[a]),
        .useRise (edgeRise_ff[a]),
        .pulse   (pinPulse[a]),
        .level   (pinLevel[a])
      );
      // Cross-coupled done: the other ADC's done is this ADC's start 1
      aptsf_edge_detect #(.DO_SYNC(1'b0)) u_done (
        .clk     (clk),
        .resetn  (resetn),
        .sigIn   (adcDone[NUM_ADC-1-a]),
        .useRise (1'b1),
        .pulse   (donePulse[a]),
        .level   ()
      );
      // Source vector and enables per ADC
      assign srcPulse[a] = {matchPulse, markerPulse, donePulse[a], pinPulse[a]};
      assign srcEn[a]    = startEn_ff[a*NUM_SRC +: NUM_SRC];
      // A stopped ADC takes no starts
      assign startNow[a] = |(srcPulse[a] & srcEn[a]) & clkEn_ff[CLK_EN_ADC_LSB + a];
    end
  endgenerate

  // Period markers of all PWMs form start 2
  aptsf_edge_detect #(.DO_SYNC(1'b0)) u_marker (
    .clk     (clk),
    .resetn  (resetn),
    .sigIn   (|pwmSyncOut),
    .useRise (1'b1),
    .pulse   (markerPulse),
    .level   ()
  );

  // Trigger timer matches form start 3 of both ADCs
  aptsf_edge_detect #(.DO_SYNC(1'b0)) u_match (
    .clk     (clk),
    .resetn  (resetn),
    .sigIn   (|trigTimerMatch),
    .useRise (1'b1),
    .pulse   (matchPulse),
    .level   ()
  );

  // Pause pin is asynchronous, level only
  aptsf_edge_detect #(.DO_SYNC(1'b1)) u_cpause (
    .clk     (clk),
    .resetn  (resetn),
    .sigIn   (carrierPausePin),
    .useRise (1'b1),
    .pulse   (),
    .level   (carrierPauseLvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Start outputs and debug capture

  // Starts also reach both timers' capture inputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adcStart            <= '0;
      trigTimerCapture    <= '0;
      carrierTimerCapture <= '0;
    end else begin
      adcStart            <= startNow;
      trigTimerCapture    <= startNow;
      carrierTimerCapture <= startNow;
    end
  end

  // Starts seen per ADC, wrapping
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startCnt0_ff <= '0;
      startCnt1_ff <= '0;
    end else begin
      startCnt0_ff <= startCnt0_ff + 8'(startNow[0]);
      startCnt1_ff <= startCnt1_ff + 8'(startNow[1]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM sync chain, carriers and timer pauses

  logic [NUM_PWM-1:0] pwmOn;
  assign pwmOn = clkEn_ff[CLK_EN_PWM_LSB +: NUM_PWM];

  // Delay itself lives in each PWM; the fabric only chains the pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwmSyncIn    <= '0;
      pwmTransArm0 <= 1'b0;
      pwmCarrier   <= '0;
    end else begin
      pwmSyncIn    <= {pwmSyncOut[NUM_PWM-2:0], trigTimerMatch[PWM_KICK_MATCH]};
      pwmTransArm0 <= trigTimerMatch[PWM_KICK_MATCH];
      pwmCarrier   <= carrierTimerMatch & pwmOn;
    end
  end

  // Gating off: the trigger timer never pauses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trigTimerPause    <= 1'b0;
      carrierTimerPause <= 1'b0;
    end else begin
      trigTimerPause    <= pauseEn_ff & ~(|pwmSyncOut);
      carrierTimerPause <= carrierPauseLvl;
    end
  end

  // Both ADC clock areas share one enable; other modules are untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adcBusClkEn  <= RST_CLK_EN[CLK_EN_ADC_LSB +: NUM_ADC];
      adcConvClkEn <= RST_CLK_EN[CLK_EN_ADC_LSB +: NUM_ADC];
      pwmClkEn     <= RST_CLK_EN[CLK_EN_PWM_LSB +: NUM_PWM];
    end else begin
      adcBusClkEn  <= clkEn_ff[CLK_EN_ADC_LSB +: NUM_ADC];
      adcConvClkEn <= clkEn_ff[CLK_EN_ADC_LSB +: NUM_ADC];
      pwmClkEn     <= pwmOn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_ff <= '0;
    end else if (rdEn) begin
      unique case (addr)
        OFS_START_EN: rdData_ff <= {24'h00_0000, startEn_ff};
        OFS_EDGE_SEL: rdData_ff <= {30'h0000_0000, edgeRise_ff};
        OFS_PAUSE:    rdData_ff <= {31'h0000_0000, pauseEn_ff};
        OFS_CLK_EN:   rdData_ff <= {26'h000_0000, clkEn_ff};
        OFS_STATUS:   rdData_ff <= {8'h00, startCnt1_ff, startCnt0_ff,
                                    5'h00, carrierPauseLvl, pinLevel};
        default:      rdData_ff <= '0;
      endcase
    end else begin
      rdData_ff <= '0;
    end
  end

  assign rdData = rdData_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Rising-edge pin of ADC 1: two sync flops, edge detect, output flop
  sequence s_pin_rise;
    ($rose(extStartPin[1]) && startEn_ff[NUM_SRC+SRC_PIN] && edgeRise_ff[1] && clkEn_ff[1])
      ##1 (extStartPin[1] && startEn_ff[NUM_SRC+SRC_PIN] && edgeRise_ff[1] && clkEn_ff[1])[*2];
  endsequence

  a_pin_start_latency: assert property (s_pin_rise |-> ##1 adcStart[1])
    else $error("pin rise did not start ADC 1 three cycles later");

  a_done_cross_start: assert property (
    ($rose(adcDone[0]) && startEn_ff[NUM_SRC+SRC_DONE] && clkEn_ff[1]) |=> adcStart[1])
    else $error("ADC 0 done did not start ADC 1");

  a_done_one_pulse: assert property (donePulse[0] |=> !donePulse[0])
    else $error("done start lasted more than one cycle");

  a_pin_one_pulse: assert property (pinPulse[1] |=> !pinPulse[1])
    else $error("pin start lasted more than one cycle");

  a_disabled_quiet: assert property (
    (startEn_ff[3:0] == 4'h0) |=> !adcStart[0])
    else $error("ADC 0 started with all sources disabled");

  a_pause_nor: assert property (
    ##1 (trigTimerPause == $past(pauseEn_ff && (pwmSyncOut == '0))))
    else $error("trigger pause is not the gated NOR of markers");

  a_kick_chain: assert property (
    $rose(trigTimerMatch[PWM_KICK_MATCH]) |=> (pwmSyncIn[0] && pwmTransArm0))
    else $error("fourth match did not reach PWM 0 sync and arm");

  a_sync_cascade: assert property (
    pwmSyncOut[1] |=> pwmSyncIn[2])
    else $error("PWM 1 sync did not cascade to PWM 2");

  a_carrier_gate: assert property (
    !clkEn_ff[CLK_EN_PWM_LSB] |=> !pwmCarrier[0])
    else $error("carrier reached a gated PWM");

  a_capture_start: assert property (adcStart[1] |-> trigTimerCapture[1])
    else $error("start pulse missing at timer capture");

  a_unmapped_zero: assert property (
    (rdEn && addr > OFS_STATUS) |=> (rdData == '0))
    else $error("unmapped read returned nonzero data");

  // Pin level needs two sync flops plus the output flop
  a_pause_pin_path: assert property (
    carrierPausePin [*3] |=> carrierTimerPause)
    else $error("carrier pause pin did not reach the carrier timer");

  a_gate_off_run: assert property (
    !pauseEn_ff |=> !trigTimerPause)
    else $error("trigger timer paused with gating off");

endmodule // aptsf_fabric

//--- bench/aptsf_far_side.sv
`timescale 1ns/1ps
// Behavioural ADC sequencers and PWM sync chain facing the fabric
module aptsf_far_side
  import aptsf_pkg::*;
#(
  parameter int DONE_LAT = 3,
  parameter int SYNC_DLY = 2
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [NUM_ADC-1:0] adcStart,
  input  wire logic [NUM_ADC-1:0] adcConvClkEn,
  input  wire logic [NUM_PWM-1:0] pwmSyncIn,
  input  wire logic [NUM_PWM-1:0] pwmClkEn,
  output logic      [NUM_ADC-1:0] adcDone,
  output logic      [NUM_PWM-1:0] pwmSyncOut
);
  logic [3:0]                        convCnt [NUM_ADC];
  logic [SYNC_DLY-1:0][NUM_PWM-1:0] syncPipe;

  ////////////////////////////////////////////////////////////////
  // Conversion starts only on a clocked converter; SYNC_DLY must be 2 or more
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      convCnt  <= '{default: 4'h0};
      syncPipe <= '0;
    end else begin
      for (int a = 0; a < NUM_ADC; a++) begin
        if (adcStart[a] && adcConvClkEn[a]) begin
          convCnt[a] <= 4'(DONE_LAT);
        end else if (convCnt[a] != 4'h0) begin
          convCnt[a] <= convCnt[a] - 4'h1;
        end
      end
      syncPipe <= {syncPipe[SYNC_DLY-2:0], pwmSyncIn};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Done lasts one cycle; a gated PWM emits no marker
  always_comb begin
    for (int a = 0; a < NUM_ADC; a++) begin
      adcDone[a] = (convCnt[a] == 4'h1);
    end
  end
  assign pwmSyncOut = syncPipe[SYNC_DLY-1] & pwmClkEn;
endmodule // aptsf_far_side

//--- bench/aptsf_fabric_tb.sv
`timescale 1ns/1ps
module aptsf_fabric_tb
  import aptsf_pkg::*;
;
  logic               clk, resetn, wrEn, rdEn, carrierPausePin;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wrData, rdData;
  logic [NUM_ADC-1:0] extStartPin, adcDone, adcStart, trigTimerCapture, carrierTimerCapture;
  logic [NUM_ADC-1:0] adcBusClkEn, adcConvClkEn;
  logic [NUM_PWM-1:0] pwmSyncOut, trigTimerMatch, carrierTimerMatch, pwmSyncIn;
  logic [NUM_PWM-1:0] pwmCarrier, pwmClkEn;
  logic               pwmTransArm0, trigTimerPause, carrierTimerPause;
  int                 fails, totalChecks, nS0, nS1, nSync3, nTpLow, nCapBad;

  aptsf_fabric u_aptsf_fabric (.clk, .resetn, .addr, .wrData, .wrEn, .rdEn, .rdData,
    .extStartPin, .adcDone, .pwmSyncOut, .trigTimerMatch, .carrierTimerMatch,
    .carrierPausePin, .adcStart, .trigTimerCapture, .carrierTimerCapture, .pwmSyncIn,
    .pwmTransArm0, .pwmCarrier, .trigTimerPause, .carrierTimerPause, .adcBusClkEn,
    .adcConvClkEn, .pwmClkEn);
  aptsf_far_side u_aptsf_far_side (.clk, .resetn, .adcStart, .adcConvClkEn, .pwmSyncIn,
    .pwmClkEn, .adcDone, .pwmSyncOut);

  ////////////////////////////////////////////////////////////////
  // Clock, and event counters sampled mid-cycle where outputs are settled
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    nS0 += int'(adcStart[0] === 1'b1);
    nS1 += int'(adcStart[1] === 1'b1);
    nSync3 += int'(pwmSyncIn[3] === 1'b1);
    nTpLow += int'(trigTimerPause === 1'b0);
    if (trigTimerCapture !== adcStart || carrierTimerCapture !== adcStart) nCapBad++;
  end

  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic void zero();
    nS0 = 0;
    nS1 = 0;
    nSync3 = 0;
    nTpLow = 0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(negedge clk);
    chk(nm, exp, rdData);
  endtask
  // Single-cycle match pulse; returns at the negedge of the cycle after it
  task automatic matchPulse(input logic [3:0] m);
    @(posedge clk);
    trigTimerMatch <= m;
    @(posedge clk);
    trigTimerMatch <= 4'h0;
    zero();
    @(negedge clk);
  endtask
  task automatic conclude;
    if (fails == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic tReset;
    chk("clkEn", 32'h0000_003F, {pwmClkEn, adcConvClkEn});
    rd(OFS_START_EN, 32'h0000_0000, "startEn");
    rd(OFS_EDGE_SEL, 32'h0000_0003, "edgeSel");
    rd(OFS_PAUSE, 32'h0000_0000, "pause");
    rd(OFS_CLK_EN, 32'h0000_003F, "clkEnReg");
    rd(8'h14, 32'h0000_0000, "unmapped");
    @(negedge clk);
    chk("rdIdle", 32'h0000_0000, rdData);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0000_0000, "statusRo");
  endtask
  // Timer match starts ADC0, whose done starts ADC1 through start 1
  task automatic tCascade;
    wr(OFS_START_EN, 32'h0000_0028);
    matchPulse(4'h1);
    chk("start0", 32'h0000_0001, adcStart);
    repeat (12) @(posedge clk);
    chk("nS0", 32'h1, nS0);
    chk("nS1", 32'h1, nS1);
    chk("capBad", 32'h0, nCapBad);
    rd(OFS_STATUS, 32'h0001_0100, "status");
  endtask
  // A held source fires once; a disabled one never
  task automatic tDisabled;
    wr(OFS_START_EN, 32'h0000_0008);
    @(posedge clk);
    trigTimerMatch <= 4'h2;
    zero();
    repeat (6) @(posedge clk);
    trigTimerMatch <= 4'h0;
    repeat (6) @(posedge clk);
    chk("heldOnce", 32'h1, nS0);
    chk("noChain", 32'h0, nS1);
    wr(OFS_START_EN, 32'h0000_0000);
    matchPulse(4'hF);
    repeat (8) @(posedge clk);
    chk("disabled", 32'h0, nS0 + nS1);
  endtask
  // ADC0 on falling pin edge, ADC1 on rising
  task automatic tPin;
    wr(OFS_EDGE_SEL, 32'h0000_0002);
    wr(OFS_START_EN, 32'h0000_0011);
    @(posedge clk);
    extStartPin <= 2'b11;
    zero();
    repeat (8) @(posedge clk);
    chk("pinRise", 32'h1, {nS0[15:0], nS1[15:0]});
    extStartPin <= 2'b00;
    repeat (8) @(posedge clk);
    chk("pinFall", 32'h0001_0001, {nS0[15:0], nS1[15:0]});
  endtask
  // Sync chain, pause gating and start 2 from period markers
  task automatic tRoute;
    wr(OFS_PAUSE, 32'h0000_0001);
    wr(OFS_START_EN, 32'h0000_0040);
    @(negedge clk);
    chk("pauseIdle", 32'h1, trigTimerPause);
    matchPulse(4'h8);
    chk("sync0", 32'h3, {pwmSyncIn[0], pwmTransArm0});
    repeat (20) @(posedge clk);
    chk("chain", 32'h1, nSync3);
    chk("runCycles", 32'h4, nTpLow);
    chk("start2", 32'h0000_0004, {nS0[15:0], nS1[15:0]});
  endtask
  task automatic tCarrier;
    @(posedge clk);
    carrierTimerMatch <= 4'hA;
    carrierPausePin <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("carrier", 32'hA, pwmCarrier);
    chk("cPause", 32'h1, carrierTimerPause);
    rd(OFS_STATUS, 32'h0006_0304, "statusPause");
    @(posedge clk);
    carrierPausePin <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("cRun", 32'h0, carrierTimerPause);
  endtask
  // Gating ADC0 clocks leaves ADC1 untouched
  task automatic tGate;
    wr(OFS_CLK_EN, 32'h0000_003A);
    carrierTimerMatch <= 4'hF;
    // Enables lag the register by one more flop
    repeat (2) @(negedge clk);
    chk("gated", 32'h0000_00EA, {pwmClkEn, adcConvClkEn, adcBusClkEn});
    chk("gatedCarrier", 32'hE, pwmCarrier);
    wr(OFS_START_EN, 32'h0000_0088);
    matchPulse(4'h1);
    repeat (8) @(posedge clk);
    chk("gatedStart", 32'h1, {nS0[15:0], nS1[15:0]});
  endtask

  ////////////////////////////////////////////////////////////////
  // Reset, scenario sequence and watchdog
  initial begin
    {resetn, wrEn, rdEn, carrierPausePin} = 4'h0;
    addr = '0;
    wrData = '0;
    extStartPin = '0;
    trigTimerMatch = '0;
    carrierTimerMatch = '0;
    fails = 0;
    totalChecks = 0;
    nCapBad = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    tReset();
    tCascade();
    tDisabled();
    tPin();
    tRoute();
    tCarrier();
    tGate();
    conclude();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // aptsf_fabric_tb
